// ### verilog/fcl_pkg.sv
/*
 * Shared constants and types of the filter configuration loader: command codes,
 * serial opcodes, timing counts, parser and master states, the word that goes
 * to the filter core, and the loader's complete state.
 * Assumes a 25 MHz core clock; every timing count below is derived from that rate.
 */
package fcl_pkg;
    // Core clock and the times derived from it
    localparam int CLK_KHZ = 25000;
    localparam int READY_PULSE_NS = 1000;
    localparam logic [4:0] READY_CYCLES = 5'(READY_PULSE_NS * CLK_KHZ / 1000000);
    localparam int PROM_SCK_KHZ = 1024;
    // Half period rounds up, so the prom clock never runs faster than nominal
    localparam logic [3:0] PROM_HALF_CYCLES =
        4'((CLK_KHZ + 2 * PROM_SCK_KHZ - 1) / (2 * PROM_SCK_KHZ));
    localparam int SAMPLE_US_DEFAULT = 2000;

    // Configuration command codes
    localparam logic [7:0] CMD_REG = 8'h01;
    localparam logic [7:0] CMD_FIR = 8'h02;
    localparam logic [7:0] CMD_IIR = 8'h03;
    localparam logic [7:0] CMD_SEL = 8'h04;
    localparam logic [7:0] CMD_PAT = 8'h05;
    localparam logic [7:0] CMD_PAT_ROM = 8'h06;
    localparam logic [7:0] CMD_START = 8'h07;
    localparam logic [10:0] IIR_WORDS = 11'h008;
    localparam logic [23:0] COEF_PRESET = 24'h002200;

    // Serial framing
    localparam logic [7:0] PROM_READ_OP = 8'h03;
    localparam logic [15:0] PROM_FIRST_ADDR = 16'h0010;
    localparam logic [7:0] HOST_WRITE_OP = 8'h02;
    localparam logic [7:0] HOST_READ_OP = 8'h03;
    localparam logic [7:0] HOST_STATUS_ADDR = 8'h01;
    localparam logic [5:0] HDR_BITS = 6'h18;
    localparam logic [5:0] HDR_LAST_DATA_BIT = 6'h1f;

    localparam int FIFO_DEPTH = 16;

    typedef enum logic [3:0] {
        P_CMD = 4'b0000, P_REG_ADDR = 4'b0001, P_REG_DATA = 4'b0010,
        P_CNT_A = 4'b0011, P_CNT_B = 4'b0100, P_FIR = 4'b0101, P_IIR = 4'b0110,
        P_SEL = 4'b0111, P_PAT_CNT = 4'b1000, P_PAT = 4'b1001, P_DONE = 4'b1010
    } fcl_parse_t;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00, M_RUN = 2'b01, M_DONE = 2'b10
    } fcl_master_t;

    typedef enum logic [3:0] {
        T_REG_ADDR = 4'b0000, T_REG_DATA = 4'b0001, T_COEF_A = 4'b0010,
        T_COEF_B = 4'b0011, T_IIR = 4'b0100, T_SEL = 4'b0101, T_PAT = 4'b0110,
        T_PAT_ROM = 4'b0111, T_START = 4'b1000
    } fcl_tag_t;

    typedef struct packed {
        fcl_tag_t tag;
        logic [23:0] data;
    } fcl_word_t;

    typedef struct packed {
        logic [1:0] bootSync;
        logic [1:0] misoSync;
        logic [1:0] mosiSync;
        logic [2:0] sckSync;
        logic [2:0] selSync;
        logic [1:0] bootWait;
        logic bootFromProm;
        fcl_parse_t ps;
        logic [23:0] acc;
        logic [1:0] byteIdx;
        logic [10:0] leftA;
        logic [10:0] leftB;
        logic pend;
        fcl_word_t pendWord;
        logic [23:0] coefSel;
        logic builtInPattern;
        logic running;
        logic [19:0] sampleCnt;
        logic firstSample;
        fcl_master_t ms;
        logic [3:0] div;
        logic sck;
        logic [5:0] bitCnt;
        logic [31:0] txSh;
        logic [7:0] rxSh;
        logic [7:0] sRx;
        logic [2:0] sBit;
        logic [1:0] sByte;
        logic [7:0] sOp;
        logic [7:0] sAddr;
        logic [7:0] sTx;
        logic armed;
        logic [4:0] pulse;
    } fcl_state_t;
endpackage

// ### verilog/fcl_loader.sv
/*
 * Configuration loader of the decimation filter, plus its output word FIFO.
 * Assumes one 25 MHz clock with synchronous active-low reset; all serial pins
 * come from outside and are resynchronised; two-way pins are split into out and
 * an active-low output enable, and the wire is resolved outside this file.
 */
`timescale 1ns/1ps

module fcl_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] count;
    } fcl_fifo_state_t;
    fcl_fifo_state_t s, next_s;
    logic doPush, doPop;

    // Full and empty come straight from the fill count
    assign inReady = (s.count != (AW + 1)'(DEPTH));
    assign outValid = (s.count != '0);
    assign outData = s.mem[s.rd];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_comb begin
        next_s = s;
        if (doPush) begin
            next_s.mem[s.wr] = inData;
            next_s.wr = s.wr + 1'b1;
        end
        if (doPop) begin
            next_s.rd = s.rd + 1'b1;
        end
        next_s.count = s.count + (AW + 1)'(doPush) - (AW + 1)'(doPop);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// Operation
// - Command 01 takes a register word then a value, writes value to it.
// - Command 02 takes two stage counts, then that many concatenated coefficients.
// - Command 03 takes exactly eight recursive filter coefficient words in order.
// - Command 04 takes one selector word choosing on-chip coefficient sets.
// - Command 05 takes a count, then that many test pattern words.
// - Command 06 picks the built-in test pattern, no data words.
// - Command 07 starts filtering; first sample one sample period later.
// - List commands accept a variable number of words after their counts.
// - Strap low after reset: accept commands from an external controller.
// - Controller boot uses only select, clock, data and ready pins.
// - Incoming data changes on falling clock, sampled on rising clock.
// - Read data shifts out on falling edges, open drain only.
// - One active-low 1 us ready pulse when ready for next transaction; the code pulses only after write frames, not after reads.
// - Host transaction: 8-bit opcode, 8-bit address, then 24-bit words.
// - Strap high after reset: act as master and read the serial prom.
// - Prom boot reads from location 10 onward until the start command.
// - Each prom fetch sends read opcode 03, a 16-bit address, then data.
// - Serial pins float whenever the port is inactive.
module fcl_loader
    import fcl_pkg::*;
#(
    parameter int SAMPLE_US = fcl_pkg::SAMPLE_US_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic bootStrap,
    input wire logic host_select_n,
    input wire logic cfgSerialClockIn,
    output logic cfgSerialClockOut,
    output logic cfgSerialClockOe_b,
    output logic prom_select_n,
    output logic promSelectOe_b,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe_b,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe_b,
    output logic ready_pulse_n,
    output logic cfgValid,
    input wire logic cfgReady,
    output fcl_pkg::fcl_word_t cfgWord,
    output logic [23:0] coef_source_select,
    output logic presetSelected,
    output logic builtInPattern,
    output logic filterRunning,
    output logic firstSampleDue
);
    import fcl_pkg::*;

    localparam logic [19:0] SAMPLE_CYCLES = 20'(SAMPLE_US * (CLK_KHZ / 1000));

    fcl_state_t s, next_s;
    logic pushReady;
    logic wordDone;
    logic [23:0] wordVal;
    logic inValid;
    logic [7:0] inByte;
    logic bootKnown, hostMode, selActive, sckRise, sckFall, busy, misoDrive;

    // Synchronised pin views; only second and third stages are looked at
    assign bootKnown = (s.bootWait == 2'h3);
    assign hostMode = bootKnown && !s.bootFromProm;
    assign selActive = hostMode && !s.selSync[1];
    assign sckRise = s.sckSync[1] && !s.sckSync[2];
    assign sckFall = !s.sckSync[1] && s.sckSync[2];
    assign busy = s.armed || s.pend;

    // Master pins drive only while a prom read runs, else they float
    assign cfgSerialClockOut = s.sck;
    assign cfgSerialClockOe_b = (s.ms != M_RUN);
    assign prom_select_n = (s.ms != M_RUN);
    assign promSelectOe_b = (s.ms != M_RUN);
    assign mosiOut = s.txSh[31];
    assign mosiOe_b = (s.ms != M_RUN);
    // Open drain: only ever pulls low, during any read's data bytes
    assign misoDrive = selActive && (s.sOp == HOST_READ_OP) && (s.sByte == 2'h2) && !s.sTx[7];
    assign misoOut = 1'b0;
    assign misoOe_b = !misoDrive;
    assign ready_pulse_n = (s.pulse == 5'h00);
    assign coef_source_select = s.coefSel;
    assign presetSelected = (s.coefSel == COEF_PRESET);
    assign builtInPattern = s.builtInPattern;
    assign filterRunning = s.running;
    assign firstSampleDue = s.firstSample;

    // Parsed words wait here until the filter core drains them
    fcl_fifo #(.WIDTH($bits(fcl_word_t)), .DEPTH(FIFO_DEPTH)) wordFifo (
        .clk(clk),
        .rst_b(rst_b),
        .inValid(s.pend),
        .inReady(pushReady),
        .inData(s.pendWord),
        .outValid(cfgValid),
        .outReady(cfgReady),
        .outData(cfgWord)
    );

    always_comb begin
        next_s = s;
        inValid = 1'b0;
        inByte = 8'h00;
        wordDone = 1'b0;
        wordVal = {s.acc[15:0], 8'h00};
        next_s.bootSync = {s.bootSync[0], bootStrap};
        next_s.misoSync = {s.misoSync[0], misoIn};
        next_s.mosiSync = {s.mosiSync[0], mosiIn};
        next_s.sckSync = {s.sckSync[1:0], cfgSerialClockIn};
        next_s.selSync = {s.selSync[1:0], host_select_n};
        next_s.firstSample = 1'b0;

        // Strap is caught once the synchroniser has filled after reset
        if (!bootKnown) begin
            next_s.bootWait = s.bootWait + 2'h1;
        end
        if (s.bootWait == 2'h2) begin
            next_s.bootFromProm = s.bootSync[1];
        end

        if (s.pend && pushReady) begin
            next_s.pend = 1'b0;
        end

        // Prom master: mode 0, clock held low while a word waits for room
        unique case (s.ms)
            M_IDLE: begin
                if (bootKnown && s.bootFromProm) begin
                    next_s.ms = M_RUN;
                    next_s.txSh = {PROM_READ_OP, PROM_FIRST_ADDR, 8'h00};
                    next_s.bitCnt = 6'h00;
                    next_s.div = 4'h0;
                end
            end
            M_RUN: begin
                next_s.div = s.div + 4'h1;
                if (s.div == PROM_HALF_CYCLES - 4'h1) begin
                    next_s.div = 4'h0;
                    if (!s.sck) begin
                        if (s.ps == P_DONE) begin
                            next_s.ms = M_DONE;
                        end else if (s.bitCnt >= HDR_BITS && s.pend) begin
                            next_s.div = s.div;
                        end else begin
                            next_s.sck = 1'b1;
                            next_s.rxSh = {s.rxSh[6:0], s.misoSync[1]};
                        end
                    end else begin
                        next_s.sck = 1'b0;
                        next_s.txSh = {s.txSh[30:0], 1'b0};
                        next_s.bitCnt = (s.bitCnt == HDR_LAST_DATA_BIT) ? HDR_BITS :
                            s.bitCnt + 6'h01;
                        if (s.bitCnt >= HDR_BITS && s.bitCnt[2:0] == 3'h7) begin
                            inValid = 1'b1;
                            inByte = s.rxSh;
                        end
                    end
                end
            end
            M_DONE: begin
                next_s.sck = 1'b0;
            end
            default: begin
                next_s.ms = M_IDLE;
            end
        endcase

        // Host slave: opcode, address, then data bytes; select high resets framing
        if (hostMode) begin
            // Ready pulse once the last write is fully taken in; a frame end below wins
            if (s.armed && !s.pend && s.pulse == 5'h00) begin
                next_s.armed = 1'b0;
                next_s.pulse = READY_CYCLES;
            end
            if (!selActive) begin
                next_s.sBit = 3'h0;
                next_s.sByte = 2'h0;
                if (s.selSync[1] && !s.selSync[2] && s.sOp == HOST_WRITE_OP) begin
                    next_s.armed = 1'b1;
                end
            end else if (sckRise) begin
                next_s.sRx = {s.sRx[6:0], s.mosiSync[1]};
                next_s.sBit = s.sBit + 3'h1;
                if (s.sBit == 3'h7) begin
                    next_s.sByte = s.sByte + {1'b0, s.sByte != 2'h2};
                    unique case (s.sByte)
                        2'h0: next_s.sOp = {s.sRx[6:0], s.mosiSync[1]};
                        2'h1: begin
                            next_s.sAddr = {s.sRx[6:0], s.mosiSync[1]};
                            next_s.sTx = ({s.sRx[6:0], s.mosiSync[1]} == HOST_STATUS_ADDR) ?
                                {7'h00, busy} : 8'h00;
                        end
                        default: begin
                            if (s.sOp == HOST_WRITE_OP) begin
                                inValid = 1'b1;
                                inByte = {s.sRx[6:0], s.mosiSync[1]};
                            end
                        end
                    endcase
                end
            end else if (sckFall && s.sBit != 3'h0) begin
                next_s.sTx = {s.sTx[6:0], 1'b0};
            end
        end
        if (s.pulse != 5'h00) begin
            next_s.pulse = s.pulse - 5'h01;
        end

        // Word assembly: prom commands are one byte, host commands a full word
        if (inValid && !s.pend) begin
            next_s.acc = {s.acc[15:0], inByte};
            wordVal = {s.acc[15:0], inByte};
            next_s.byteIdx = s.byteIdx + 2'h1;
            if ((s.ps == P_CMD && s.bootFromProm) || s.byteIdx == 2'h2) begin
                next_s.byteIdx = 2'h0;
                wordDone = 1'b1;
            end
        end

        if (wordDone) begin
            unique case (s.ps)
                P_CMD: begin
                    unique case (wordVal[7:0])
                        CMD_REG: next_s.ps = P_REG_ADDR;
                        CMD_FIR: next_s.ps = P_CNT_A;
                        CMD_IIR: begin
                            next_s.ps = P_IIR;
                            next_s.leftA = IIR_WORDS;
                        end
                        CMD_SEL: next_s.ps = P_SEL;
                        CMD_PAT: next_s.ps = P_PAT_CNT;
                        CMD_PAT_ROM: begin
                            next_s.builtInPattern = 1'b1;
                            next_s.pend = 1'b1;
                            next_s.pendWord = '{T_PAT_ROM, wordVal};
                        end
                        CMD_START: begin
                            next_s.ps = P_DONE;
                            next_s.running = 1'b1;
                            next_s.sampleCnt = SAMPLE_CYCLES;
                            next_s.pend = 1'b1;
                            next_s.pendWord = '{T_START, wordVal};
                        end
                        default: next_s.ps = P_CMD;
                    endcase
                end
                P_REG_ADDR: begin
                    next_s.ps = P_REG_DATA;
                    next_s.pend = 1'b1;
                    next_s.pendWord = '{T_REG_ADDR, wordVal};
                end
                P_REG_DATA: begin
                    next_s.ps = P_CMD;
                    next_s.pend = 1'b1;
                    next_s.pendWord = '{T_REG_DATA, wordVal};
                end
                P_CNT_A: begin
                    next_s.leftA = wordVal[10:0];
                    next_s.ps = P_CNT_B;
                end
                P_CNT_B: begin
                    next_s.leftB = wordVal[10:0];
                    next_s.ps = (s.leftA == 11'h000 && wordVal[10:0] == 11'h000) ? P_CMD : P_FIR;
                end
                P_FIR: begin
                    next_s.pend = 1'b1;
                    if (s.leftA != 11'h000) begin
                        next_s.leftA = s.leftA - 11'h001;
                        next_s.pendWord = '{T_COEF_A, wordVal};
                    end else begin
                        next_s.leftB = s.leftB - 11'h001;
                        next_s.pendWord = '{T_COEF_B, wordVal};
                    end
                    if (s.leftA + s.leftB == 11'h001) begin
                        next_s.ps = P_CMD;
                    end
                end
                P_IIR: begin
                    next_s.pend = 1'b1;
                    next_s.pendWord = '{T_IIR, wordVal};
                    next_s.leftA = s.leftA - 11'h001;
                    if (s.leftA == 11'h001) begin
                        next_s.ps = P_CMD;
                    end
                end
                P_SEL: begin
                    next_s.coefSel = wordVal;
                    next_s.pend = 1'b1;
                    next_s.pendWord = '{T_SEL, wordVal};
                    next_s.ps = P_CMD;
                end
                P_PAT_CNT: begin
                    next_s.leftA = wordVal[10:0];
                    next_s.builtInPattern = 1'b0;
                    next_s.ps = (wordVal[10:0] == 11'h000) ? P_CMD : P_PAT;
                end
                P_PAT: begin
                    next_s.pend = 1'b1;
                    next_s.pendWord = '{T_PAT, wordVal};
                    next_s.leftA = s.leftA - 11'h001;
                    if (s.leftA == 11'h001) begin
                        next_s.ps = P_CMD;
                    end
                end
                P_DONE: next_s.ps = P_DONE;
                default: next_s.ps = P_CMD;
            endcase
        end

        // First sample falls due one full sample period after start
        if (s.running && s.sampleCnt != 20'h00000) begin
            next_s.sampleCnt = s.sampleCnt - 20'h00001;
            if (s.sampleCnt == 20'h00001) begin
                next_s.firstSample = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence pulseStart;
        $fell(ready_pulse_n);
    endsequence
    sequence pulseBody;
        ##24 !ready_pulse_n ##1 ready_pulse_n;
    endsequence

    ready_pulse_width_a: assert property (pulseStart |-> pulseBody)
        else $error("ready pulse not 25 cycles long");
    pins_released_a: assert property ((s.ms != M_RUN) |->
        cfgSerialClockOe_b && mosiOe_b && promSelectOe_b)
        else $error("serial pins driven while port idle");
    host_pins_idle_a: assert property (hostMode |-> cfgSerialClockOe_b && prom_select_n)
        else $error("master pins active in host boot");
    prom_header_a: assert property ((s.ms == M_IDLE && next_s.ms == M_RUN) |=>
        s.txSh[31:8] == {PROM_READ_OP, PROM_FIRST_ADDR})
        else $error("prom read header wrong");
    start_cmd_a: assert property ((wordDone && s.ps == P_CMD && wordVal[7:0] == CMD_START) |=>
        s.ps == P_DONE && s.running && s.pend && s.pendWord.tag == T_START)
        else $error("start command not taken");
    first_sample_a: assert property (firstSampleDue |-> s.running && $past(s.sampleCnt) == 20'h00001)
        else $error("first sample at wrong time");
    iir_count_a: assert property ((wordDone && s.ps == P_CMD && wordVal[7:0] == CMD_IIR) |=>
        s.ps == P_IIR && s.leftA == IIR_WORDS)
        else $error("iir word count not eight");
    reg_pair_a: assert property ((wordDone && s.ps == P_REG_ADDR) |=>
        s.pend && s.pendWord.tag == T_REG_ADDR && s.ps == P_REG_DATA)
        else $error("register address not forwarded");
    sel_store_a: assert property ((wordDone && s.ps == P_SEL) |=>
        coef_source_select == $past(wordVal) && s.ps == P_CMD)
        else $error("selector word not stored");
    mosi_on_fall_a: assert property ((s.ms == M_RUN && $past(s.ms) == M_RUN && $changed(mosiOut))
        |-> !s.sck && $fell(s.sck))
        else $error("prom data changed outside falling clock");
endmodule

// ### tb/fcl_host_model.sv
/* Far-side models: a host controller framing SPI mode 0 writes, and a serial prom
   answering one long read. Assumes the bench clock; serial clocks idle low. */
`timescale 1ns/1ps
module fcl_host_model (
    input wire logic clk,
    output logic host_select_n,
    output logic sck,
    output logic mosi
);
    initial begin
        host_select_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b1;
    end
    // Four clocks a half bit: 320 ns serial period, below the maximum rate
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // Select low for the frame, data moves in the low phase
    task automatic frame(input logic [87:0] bits);
        @(posedge clk);
        host_select_n <= 1'b0;
        for (int i = 87; i >= 0; i--) begin
            mosi <= bits[i];
            half();
            sck <= 1'b1;
            half();
            sck <= 1'b0;
        end
        half();
        host_select_n <= 1'b1;
        mosi <= ~mosi; // Stale bit must not linger
    endtask
endmodule

// Serial prom model: one long read, data launched after falling clocks
module fcl_prom_model (
    input wire logic clk,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic [23:0] header
);
    // Image from location 10: selector command, preset word, start command
    logic [39:0] image = 40'h0400220007;
    logic sckLast = 1'b0;
    int nBit = 0;
    always @(posedge clk) begin
        sckLast <= sck;
        if (sel_n) begin
            nBit <= 0;
            miso <= 1'b1; // Released line rests at its pull-up
        end else if (sck && !sckLast) begin
            if (nBit < 24) header <= {header[22:0], mosi};
            nBit <= nBit + 1;
        end else if (!sck && sckLast && nBit >= 24 && nBit < 64) begin
            miso <= image[63 - nBit];
        end
    end
endmodule

// ### tb/fcl_loader_bench.sv
/* Bench of the loader: host write frames, list commands, word stream, ready pulse
   and start timing, then a prom boot after a second reset.
   Assumes fcl_pkg, the host model and the prom model. */
`timescale 1ns/1ps
module fcl_loader_bench;
    import fcl_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cfgReady = 1'b0;
    logic hostSel_n, hostSck, hostMosi, misoIn, sckIn, sckOut, sckOe_b, mosiOe_b;
    logic misoOut, misoOe_b, selOe_b, cfgValid, readyPulse_n, running, due, preset, builtIn;
    fcl_word_t cfgWord;
    logic strap = 1'b0;
    logic promSel_n, promMosi, promMiso;
    logic [23:0] coefSel, promHdr;
    fcl_word_t seen[$];
    int n_errors = 0;
    int check_count = 0;
    int sinceStart = -1;
    int dueAt = -1;
    // Open-drain pull wins; a released line rests at the prom model's pull-up level
    assign misoIn = misoOe_b ? promMiso : misoOut;
    assign sckIn = sckOe_b ? hostSck : sckOut;
    fcl_host_model u_host (.clk(clk), .host_select_n(hostSel_n), .sck(hostSck), .mosi(hostMosi));
    fcl_prom_model u_prom (.clk(clk), .sel_n(promSel_n), .sck(sckOut), .mosi(promMosi),
        .miso(promMiso), .header(promHdr));
    // Short sample period keeps the start wait at 50 cycles
    fcl_loader #(.SAMPLE_US(2)) u_dut (
        .clk(clk), .rst_b(rst_b), .bootStrap(strap), .host_select_n(hostSel_n),
        .cfgSerialClockIn(sckIn), .cfgSerialClockOut(sckOut), .cfgSerialClockOe_b(sckOe_b),
        .prom_select_n(promSel_n), .promSelectOe_b(selOe_b), .mosiIn(hostMosi),
        .mosiOut(promMosi),
        .mosiOe_b(mosiOe_b), .misoIn(misoIn), .misoOut(misoOut), .misoOe_b(misoOe_b),
        .ready_pulse_n(readyPulse_n), .cfgValid(cfgValid), .cfgReady(cfgReady),
        .cfgWord(cfgWord), .coef_source_select(coefSel), .presetSelected(preset),
        .builtInPattern(builtIn), .filterRunning(running), .firstSampleDue(due)
    );
    initial forever #20 clk = ~clk;
    // Consumer of the word stream, plus start-to-sample counter
    always @(negedge clk) begin
        if (cfgValid === 1'b1 && cfgReady === 1'b1) seen.push_back(cfgWord);
        if (running === 1'b1) sinceStart++;
        if (due === 1'b1) dueAt = sinceStart;
    end
    task automatic check(input logic [27:0] got, input logic [27:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Mismatches %0d of %0d checks", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One frame, then the width of the single ready pulse
    task automatic send(input logic [87:0] bits);
        int w;
        w = 0;
        u_host.frame(bits);
        for (int i = 0; i < 3000 && readyPulse_n !== 1'b0; i++) @(negedge clk);
        while (readyPulse_n === 1'b0 && w < 100) begin
            @(negedge clk);
            w++;
        end
        check(28'(w), 28'(READY_CYCLES));
        repeat (5) @(negedge clk);
    endtask
    task automatic t_reg();
        send({16'h0203, 24'h000001, 24'h000010, 24'h00abcd});
        check(seen[0], {T_REG_ADDR, 24'h000010});
        check(seen[1], {T_REG_DATA, 24'h00abcd});
    endtask
    // Selector and built-in pattern in one frame
    task automatic t_sel();
        send({16'h0203, 24'h000004, 24'h002200, 24'h000006});
        check(seen[2], {T_SEL, 24'h002200});
        check(28'(seen[3].tag), 28'(T_PAT_ROM));
        check(28'(coefSel), 28'h0002200);
        check(28'({preset, builtIn}), 28'h3);
    endtask
    // Two no-ops then start; pins stay released in host boot
    task automatic t_start();
        send({16'h0203, 24'h000000, 24'h000000, 24'h000007});
        check(28'(seen.size()), 28'h10);
        check(28'(seen[15].tag), 28'(T_START));
        repeat (80) @(negedge clk);
        check(28'(running), 28'h1);
        check(28'(dueAt), 28'h32);
        check(28'({mosiOe_b, selOe_b, sckOe_b, misoOe_b}), 28'hf);
    endtask
    // List commands over several frames: two coefficients, one pattern word, eight iir words
    task automatic t_lists();
        send({16'h0203, 24'h000002, 24'h000001, 24'h000001});
        send({16'h0203, 24'h00022e, 24'hfffe8d, 24'h000005});
        send({16'h0203, 24'h000001, 24'h0007da, 24'h000003});
        send({16'h0203, 24'h0000a1, 24'h0000a2, 24'h0000a3});
        send({16'h0203, 24'h0000a4, 24'h0000a5, 24'h0000a6});
        send({16'h0203, 24'h0000a7, 24'h0000a8, 24'h000000});
        check(seen[4], {T_COEF_A, 24'h00022e});
        check(seen[5], {T_COEF_B, 24'hfffe8d});
        check(seen[6], {T_PAT, 24'h0007da});
        check(28'(builtIn), 28'h0);
        check(seen[7], {T_IIR, 24'h0000a1});
        check(seen[14], {T_IIR, 24'h0000a8});
    endtask
    // Second reset with the strap high: the loader boots itself from the prom model
    task automatic t_prom();
        @(posedge clk);
        rst_b <= 1'b0;
        strap <= 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 3000 && running !== 1'b1; i++) @(negedge clk);
        repeat (30) @(negedge clk);
        check(28'(promHdr), 28'h0030010);
        check(seen[16], {T_SEL, 24'h002200});
        check(28'({running, mosiOe_b, selOe_b, sckOe_b}), 28'hf);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        cfgReady <= 1'b1;
        repeat (10) @(posedge clk);
        t_reg();
        t_sel();
        t_lists();
        t_start();
        t_prom();
        tally_and_finish();
    end
    // Nine frames and the prom boot take about 350 us
    initial begin
        #1000000;
        n_errors++;
        tally_and_finish();
    end
endmodule
